/* File: bench/li_partner.sv */
/*
 adjacent logic cluster model: drives the local interconnect, clock,
 enable and clear sources of the block; assumes the bench's pclk
*/
`timescale 1ns/10ps
`default_nettype none

module li_partner (
	input  wire logic        pclk,
	output logic      [31:0] li_in,
	output logic      [1:0]  ded_clk,
	output logic      [1:0]  glob_clk,
	output logic      [1:0]  li_clk,
	output logic      [1:0]  li_ce,
	output logic      [1:0]  glob_clr,
	output logic      [1:0]  li_clr
);
	initial begin
		li_in = '0;
		ded_clk = '0;
		glob_clk = '0;
		li_clk = '0;
		li_ce = '0;
		glob_clr = '0;
		li_clr = '0;
	end

	// levels change just after an edge, like a neighbouring register would
	task automatic put(input logic [31:0] v, input logic [1:0] ce, input logic [1:0] clr);
		@(posedge pclk);
		li_in <= v;
		li_ce <= ce;
		glob_clr <= clr;
	endtask

	task automatic set_lclr(input logic [1:0] c);
		@(posedge pclk);
		li_clr <= c;
	endtask

	// clock stands still outside the pulse; 3 cycles each phase so the sync sees it
	// src picks the pin (0), global (1) or local (2) source of block clock k
	task automatic pulse(input int k, input int src = 0);
		@(posedge pclk);
		edge_to(k, src, 1'b1);
		repeat (3) @(posedge pclk);
		edge_to(k, src, 1'b0);
		repeat (3) @(posedge pclk);
	endtask

	task automatic edge_to(input int k, input int src, input logic lvl);
		if (src == 1)
			glob_clk[k] <= lvl;
		else if (src == 2)
			li_clk[k] <= lvl;
		else
			ded_clk[k] <= lvl;
	endtask
endmodule

`default_nettype wire

/* File: bench/test_product_term_macrocell_array.sv */
/*
 self-checking bench: APB configuration, combinational and registered
 macrocell paths; assumes ptm_pkg and ptm_map.svh are compiled first
*/
`timescale 1ns/10ps
`default_nettype none

module test_product_term_macrocell_array;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] li_in;
	logic [1:0]  ded_clk;
	logic [1:0]  glob_clk;
	logic [1:0]  li_clk;
	logic [1:0]  li_ce;
	logic [1:0]  glob_clr;
	logic [1:0]  li_clr;
	logic [15:0] mc_out;
	logic [32:0] exp_q[$];
	logic [15:0] exp_o[$];
	logic        look = 1'b0;
	logic [31:0] v;
	int          b;
	int          err_count = 0;
	int          tests_run = 0;
	int          cyc = 0;

	product_term_macrocell_array u_product_term_macrocell_array (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .li_in(li_in), .ded_clk(ded_clk), .glob_clk(glob_clk),
		.li_clk(li_clk), .li_ce(li_ce), .glob_clr(glob_clr), .li_clr(li_clr),
		.mc_out(mc_out));

	li_partner u_li_partner (.pclk(pclk), .li_in(li_in), .ded_clk(ded_clk),
		.glob_clk(glob_clk), .li_clk(li_clk), .li_ce(li_ce),
		.glob_clr(glob_clr), .li_clr(li_clr));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task final_report;
		$display("mismatches %0d comparisons %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
		exp_q.push_back({e, d});
		apb(1'b0, a, 32'h0);
	endtask

	// status with mc0 = s and the fifteen untouched macrocells at 1
	function automatic logic [31:0] st(input logic s);
		return {7'h00, 8'hff, s, 15'h7fff, s};
	endfunction

	task automatic chk(input logic [32:0] got, input logic [32:0] want);
		tests_run++;
		if (got !== want) begin
			err_count++;
			$display("Error at %0t: read got %h want %h", $time, got, want);
		end
	endtask

	task automatic chk_out(input logic [15:0] got, input logic [15:0] want);
		tests_run++;
		if (got !== want) begin
			err_count++;
			$display("Error at %0t: outputs got %h want %h", $time, got, want);
		end
	endtask

	// outputs are looked at once the input syncs have settled
	task automatic see(input logic [15:0] want);
		exp_o.push_back(want);
		repeat (3) @(posedge pclk);
		look <= 1'b1;
		@(posedge pclk);
		look <= 1'b0;
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, exp_q.pop_front());
	end

	always @(posedge pclk) begin
		if (look)
			chk_out(mc_out, exp_o.pop_front());
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		void'($urandom(32'hbfab));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 32'h0, 1'b0);
		rd(12'h004, 32'h0, 1'b0);
		rd(12'h07c, 32'h0, 1'b0);
		rd(12'h0c0, 32'h0, 1'b1);
		apb(1'b1, 12'h000, 32'h1);
		// inverted empty term1 reads 0, so mc0 follows term0 alone
		apb(1'b1, 12'h040, 32'h2);
		for (int i = 0; i < 4; i++) begin
			b = $urandom % 32;
			v = $urandom;
			apb(1'b1, 12'h200, 32'h1 << b);
			u_li_partner.put(v, 2'h0, 2'h0);
			repeat (4) @(posedge pclk);
			rd(12'h00c, st(v[b]), 1'b0);
			see({15'h7fff, v[b]});
		end
		apb(1'b1, 12'h200, 32'h1);
		apb(1'b1, 12'h040, 32'h23);
		u_li_partner.put(32'h1, 2'h1, 2'h0);
		u_li_partner.pulse(0);
		rd(12'h00c, st(1'b1), 1'b0);
		u_li_partner.put(32'h0, 2'h0, 2'h0);
		u_li_partner.pulse(0);
		rd(12'h00c, st(1'b1), 1'b0);
		u_li_partner.put(32'h0, 2'h1, 2'h0);
		u_li_partner.pulse(0);
		rd(12'h00c, st(1'b0), 1'b0);
		u_li_partner.put(32'h1, 2'h1, 2'h0);
		u_li_partner.pulse(0);
		u_li_partner.put(32'h1, 2'h1, 2'h1);
		repeat (4) @(posedge pclk);
		rd(12'h00c, st(1'b0), 1'b0);
		see(16'hfffe);
		u_li_partner.put(32'h1, 2'h1, 2'h0);
		u_li_partner.pulse(0);
		rd(12'h00c, st(1'b1), 1'b0);
		apb(1'b1, 12'h008, 32'h2);
		repeat (4) @(posedge pclk);
		rd(12'h00c, st(1'b0), 1'b0);
		rd(12'h008, 32'h2, 1'b0);
		// mc1: clock 1 from the local line on its falling edge, T type, clear B
		apb(1'b1, 12'h004, 32'h60);
		apb(1'b1, 12'h008, 32'h6);
		apb(1'b1, 12'h220, 32'h2);
		apb(1'b1, 12'h044, 32'h57);
		u_li_partner.put(32'h3, 2'h2, 2'h0);
		u_li_partner.set_lclr(2'h2);
		see(16'hfffc);
		u_li_partner.set_lclr(2'h0);
		u_li_partner.pulse(1, 2);
		see(16'hfffe);
		u_li_partner.pulse(1, 0);
		u_li_partner.pulse(1, 1);
		see(16'hfffe);
		rd(12'h00c, 32'h01fe_fffe, 1'b0);
		u_li_partner.set_lclr(2'h2);
		see(16'hfffc);
		// mc3 lends its first term to mc2, whose XOR inverts the sum
		apb(1'b1, 12'h240, 32'h4);
		apb(1'b1, 12'h260, 32'h8);
		apb(1'b1, 12'h04c, 32'h80);
		apb(1'b1, 12'h048, 32'h602);
		u_li_partner.put(32'h0, 2'h0, 2'h0);
		see(16'hfffc);
		u_li_partner.put(32'h8, 2'h0, 2'h0);
		see(16'hfff8);
		repeat (3) @(posedge pclk);
		final_report();
	end
endmodule

`default_nettype wire

/* File: logic/product_term_macrocell_array.sv */
/*
 embedded array block in product-term operation: 16 macrocells with
 expanders, programmable registers and an APB configuration port.
 assumes APB master on pclk; all other inputs are asynchronous to pclk.
*/
// Chosen here: the register offsets and the APB interface to the registers.
// Operation
// R1: product-term operation is enabled per block by its own control bit.
// R2: the block takes 32 logic inputs from the local interconnect.
// R3: nine macrocell outputs feed back into the block as inputs.
// R4: the block provides 16 macrocells.
// R5: each macrocell owns two product terms and one register.
// R6: each macrocell is registered or combinational; combinational bypasses the register.
// R7: each term goes to own OR/XOR gates or out as parallel expander.
// R8: one product term per macrocell may be inverted.
// R9: each register acts as D, T, JK or SR flip-flop.
// R10: each register uses one of two block-wide clocks.
// R11: each block clock comes from clock pin, global signal or local line.
// R12: each block clock has a local enable gating every macrocell using it.
// R13: rising and falling edges in one block use both block clocks.
// R14: two asynchronous clears come from global signals or local lines.
// R15: each register selects clear A, clear B or no clear.
// R16: either clear may be inverted inside the block.
// R17: up to 32 terms feed one OR gate: two own plus 30 borrowed.
// R18: borrowing is up to 15 sets of two expanders each.
// R19: an asserted selected clear zeroes the register output at once.
`timescale 1ns/10ps
`default_nettype none
`include "ptm_map.svh"

module product_term_macrocell_array (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] li_in,
	input  wire logic [1:0]  ded_clk,
	input  wire logic [1:0]  glob_clk,
	input  wire logic [1:0]  li_clk,
	input  wire logic [1:0]  li_ce,
	input  wire logic [1:0]  glob_clr,
	input  wire logic [1:0]  li_clr,
	output logic      [15:0] mc_out
);
	import ptm_pkg::*;

	logic [43:0] pin_s1_r;
	logic [43:0] pin_s2_r;
	logic [31:0] li_s;
	logic [1:0]  ce_s;
	logic        mode_r;
	logic [7:0]  clkcfg_r;
	logic [3:0]  clrcfg_r;
	logic [10:0] mccfg_r [`NUM_MC];
	logic [40:0] tmask_r [2*`NUM_MC];
	logic [40:0] cmask_r [2*`NUM_MC];
	logic [31:0] prdata_r;
	logic [31:0] rd_mux;
	logic [8:0]  fb_r;
	logic [40:0] xin;
	logic [31:0] term_v;
	logic [15:0] exp_v;
	logic [15:0] chain_v;
	logic [15:0] sum_v;
	logic [15:0] comb_v;
	logic [15:0] regd_v;
	logic [15:0] clr_hit;
	logic [15:0] q_r;
	logic [1:0]  clk_raw;
	logic [1:0]  clk_d_r;
	logic [1:0]  tick;
	logic [1:0]  clr_v;
	logic        wr_en;

	function automatic logic is_mc(input logic [11:0] a);
		is_mc = (a >= `MCCFG_BASE) && (a < `MCCFG_END);
	endfunction

	function automatic logic is_term(input logic [11:0] a);
		is_term = (a >= `TERM_BASE) && (a < `TERM_END);
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[1:0] == 2'h0) &&
			((a <= `STATUS_OFS) || is_mc(a) || is_term(a));
	endfunction

	// an empty term (no literal selected) evaluates to one
	function automatic logic term_eval(
		input logic [40:0] t,
		input logic [40:0] c,
		input logic [40:0] x
	);
		term_eval = &((~t | x) & (~c | ~x));
	endfunction

	function automatic logic ff_next(
		input ff_kind_t k,
		input logic     q,
		input logic     a,
		input logic     b
	);
		unique case (k)
			FF_D:  ff_next = a;
			FF_T:  ff_next = q ^ a;
			FF_JK: ff_next = (a & ~q) | (~b & q);
			FF_SR: ff_next = a | (~b & q);
		endcase
	endfunction

	// every pin passes two flops; only the second stage is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 44'h000_0000_0000;
			pin_s2_r <= 44'h000_0000_0000;
		end else begin
			pin_s1_r <= {li_clr, glob_clr, li_ce, li_clk, glob_clk, ded_clk, li_in};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign li_s = pin_s2_r[31:0]; // R2
	assign ce_s = pin_s2_r[39:38];

	// register bus: zero wait states, read data captured in setup phase
	assign wr_en = psel & penable & pwrite & mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign prdata = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= `CTRL_RST;
			clkcfg_r <= `CLKCFG_RST;
			clrcfg_r <= `CLRCFG_RST;
			for (int i = 0; i < `NUM_MC; i++) begin
				mccfg_r[i] <= `MCCFG_RST;
			end
			for (int i = 0; i < 2*`NUM_MC; i++) begin
				tmask_r[i] <= `MASK_RST;
				cmask_r[i] <= `MASK_RST;
			end
		end else if (wr_en) begin
			if (paddr == `CTRL_OFS) begin
				mode_r <= pwdata[0]; // R1
			end else if (paddr == `CLKCFG_OFS) begin
				clkcfg_r <= pwdata[7:0];
			end else if (paddr == `CLRCFG_OFS) begin
				clrcfg_r <= pwdata[3:0];
			end else if (is_mc(paddr)) begin
				mccfg_r[paddr[5:2]] <= pwdata[10:0];
			end else if (is_term(paddr)) begin
				unique case (paddr[3:2])
					2'h0: tmask_r[paddr[8:4]][31:0] <= pwdata;
					2'h1: tmask_r[paddr[8:4]][40:32] <= pwdata[8:0];
					2'h2: cmask_r[paddr[8:4]][31:0] <= pwdata;
					2'h3: cmask_r[paddr[8:4]][40:32] <= pwdata[8:0];
				endcase
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (!mapped(paddr)) begin
			rd_mux = 32'h0000_0000;
		end else if (paddr == `CTRL_OFS) begin
			rd_mux = {31'h0000_0000, mode_r};
		end else if (paddr == `CLKCFG_OFS) begin
			rd_mux = {24'h00_0000, clkcfg_r};
		end else if (paddr == `CLRCFG_OFS) begin
			rd_mux = {28'h000_0000, clrcfg_r};
		end else if (paddr == `STATUS_OFS) begin
			rd_mux = {7'h00, fb_r, mc_out};
		end else if (is_mc(paddr)) begin
			rd_mux = {21'h00_0000, mccfg_r[paddr[5:2]]};
		end else begin
			unique case (paddr[3:2])
				2'h0: rd_mux = tmask_r[paddr[8:4]][31:0];
				2'h1: rd_mux = {23'h00_0000, tmask_r[paddr[8:4]][40:32]};
				2'h2: rd_mux = cmask_r[paddr[8:4]][31:0];
				2'h3: rd_mux = {23'h00_0000, cmask_r[paddr[8:4]][40:32]};
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	// block clocks: source mux, then edge detect qualified by enable
	always_comb begin
		clk_raw = 2'h0;
		for (int k = 0; k < 2; k++) begin
			unique case (clkcfg_r[k*`CLK_FLD +: 2])
				SRC_PIN:    clk_raw[k] = pin_s2_r[32+k]; // R11
				SRC_GLOBAL: clk_raw[k] = pin_s2_r[34+k]; // R11
				SRC_LOCAL:  clk_raw[k] = pin_s2_r[36+k]; // R11
				default:    clk_raw[k] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_d_r <= 2'h0;
		end else begin
			clk_d_r <= clk_raw;
		end
	end

	// a rising-edge and a falling-edge group need one block clock each
	always_comb begin
		tick = 2'h0;
		for (int k = 0; k < 2; k++) begin
			if (clkcfg_r[k*`CLK_FLD + `CLK_FALL]) begin
				tick[k] = ce_s[k] & clk_d_r[k] & ~clk_raw[k]; // R12 R13
			end else begin
				tick[k] = ce_s[k] & ~clk_d_r[k] & clk_raw[k]; // R12 R13
			end
		end
	end

	// clear sources and optional inversion
	always_comb begin
		clr_v = 2'h0;
		for (int k = 0; k < 2; k++) begin
			clr_v[k] = clrcfg_r[k*`CLR_FLD] ? pin_s2_r[42+k] : pin_s2_r[40+k]; // R14
			clr_v[k] = clr_v[k] ^ clrcfg_r[k*`CLR_FLD + `CLR_INV]; // R16
		end
	end

	// feedback is registered once so that no combinational loop forms
	assign xin = {fb_r, li_s}; // R3

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_r <= 9'h000;
		end else begin
			fb_r <= mc_out[8:0]; // R3
		end
	end

	// two terms per macrocell; the second may be inverted
	always_comb begin
		term_v = 32'h0000_0000;
		for (int t = 0; t < 2*`NUM_MC; t++) begin
			term_v[t] = term_eval(tmask_r[t], cmask_r[t], xin); // R5
			if (t[0] && mccfg_r[t/2][`MC_INV]) begin
				term_v[t] = ~term_v[t]; // R8
			end
		end
	end

	// expander chain: a macrocell borrowing set m+1 reaches up to 15 sets
	always_comb begin
		exp_v = 16'h0000;
		chain_v = 16'h0000;
		for (int m = `NUM_MC - 1; m >= 0; m--) begin
			exp_v[m] = (term_v[2*m] & mccfg_r[m][`MC_EXP0]) |
				(term_v[2*m+1] & mccfg_r[m][`MC_EXP1]); // R7
			chain_v[m] = exp_v[m];
			if (m < `NUM_MC - 1 && mccfg_r[m][`MC_BORROW]) begin
				chain_v[m] = exp_v[m] | chain_v[m+1]; // R18
			end
		end
	end

	// JK and SR take their second input from the second own term
	always_comb begin
		sum_v = 16'h0000;
		comb_v = 16'h0000;
		regd_v = 16'h0000;
		clr_hit = 16'h0000;
		for (int m = 0; m < `NUM_MC; m++) begin
			sum_v[m] = term_v[2*m] & ~mccfg_r[m][`MC_EXP0]; // R7
			if (!mccfg_r[m][`MC_FF+1]) begin
				sum_v[m] = sum_v[m] | (term_v[2*m+1] & ~mccfg_r[m][`MC_EXP1]);
			end
			if (m < `NUM_MC - 1 && mccfg_r[m][`MC_BORROW]) begin
				sum_v[m] = sum_v[m] | chain_v[m+1]; // R17
			end
			comb_v[m] = sum_v[m] ^ mccfg_r[m][`MC_XOR];
			regd_v[m] = mccfg_r[m][`MC_REGD];
			unique case (mccfg_r[m][`MC_CLR +: 2])
				CLR_A:   clr_hit[m] = clr_v[0]; // R15
				CLR_B:   clr_hit[m] = clr_v[1]; // R15
				default: clr_hit[m] = 1'b0;
			endcase
		end
	end

	// macrocell registers; an active clear wins over any clock tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= 16'h0000;
		end else begin
			for (int m = 0; m < `NUM_MC; m++) begin
				if (clr_hit[m]) begin
					q_r[m] <= 1'b0; // R19
				end else if (mode_r && tick[mccfg_r[m][`MC_CSEL]]) begin // R10 R12
					q_r[m] <= ff_next(ff_kind_t'(mccfg_r[m][`MC_FF +: 2]),
						q_r[m], comb_v[m], term_v[2*m+1]); // R9
				end
			end
		end
	end

	// registered outputs are gated by the clear so they drop in the same cycle
	always_comb begin
		mc_out = 16'h0000;
		for (int m = 0; m < `NUM_MC; m++) begin // R4
			if (!mode_r) begin
				mc_out[m] = 1'b0; // R1
			end else if (regd_v[m]) begin
				mc_out[m] = q_r[m] & ~clr_hit[m]; // R19
			end else begin
				mc_out[m] = comb_v[m]; // R6
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_clr_hit;
		clr_hit != 16'h0000;
	endsequence

	sequence s_rise0;
		!clkcfg_r[`CLK_FALL] && tick[0];
	endsequence

	sequence s_fall1;
		clkcfg_r[`CLK_FLD + `CLK_FALL] && tick[1];
	endsequence

	a_mode_off_quiet: assert property ( // R1
		!mode_r |-> mc_out == 16'h0000)
		else $error("outputs active with block disabled");

	a_feedback_path: assert property ( // R3
		1'b1 |=> xin[40:32] == $past(mc_out[8:0]))
		else $error("feedback inputs do not follow outputs");

	a_comb_bypass: assert property ( // R6
		mode_r |-> (mc_out & ~regd_v) == (comb_v & ~regd_v))
		else $error("combinational macrocell not bypassing register");

	a_clear_forces: assert property ( // R19
		s_clr_hit |-> (mc_out & clr_hit) == 16'h0000)
		else $error("cleared macrocell output not zero");

	a_clear_zero: assert property ( // R15
		s_clr_hit |=> (q_r & $past(clr_hit)) == 16'h0000)
		else $error("selected clear did not zero register");

	a_hold_no_tick: assert property ( // R12
		(tick == 2'h0 && clr_hit == 16'h0000) |=> $stable(q_r))
		else $error("register changed without clock tick");

	a_rise_edge: assert property ( // R13
		s_rise0 |-> $rose(clk_raw[0]) && ce_s[0])
		else $error("rising tick without rising edge and enable");

	a_fall_edge: assert property ( // R13
		s_fall1 |-> $fell(clk_raw[1]) && ce_s[1])
		else $error("falling tick without falling edge and enable");

	a_read_ctrl: assert property (
		(psel && penable && !pwrite && paddr == `CTRL_OFS) |-> prdata[0] == mode_r)
		else $error("control readback mismatch");

endmodule

`default_nettype wire

/* File: logic/ptm_map.svh */
/*
 register offsets, field positions, reset values and widths of the
 product-term macrocell array; assumes a 12-bit APB byte address
*/
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH
`define NUM_LI        32
`define NUM_FB        9
`define NUM_MC        16
`define NUM_IN        41
`define CTRL_OFS      12'h000
`define CLKCFG_OFS    12'h004
`define CLRCFG_OFS    12'h008
`define STATUS_OFS    12'h00c
`define MCCFG_BASE    12'h040
`define MCCFG_END     12'h080
`define TERM_BASE     12'h200
`define TERM_END      12'h400
`define MC_REGD       0
`define MC_INV        1
`define MC_FF         2
`define MC_CSEL       4
`define MC_CLR        5
`define MC_EXP0       7
`define MC_EXP1       8
`define MC_BORROW     9
`define MC_XOR        10
`define CLK_FLD       4
`define CLK_FALL      2
`define CLR_FLD       2
`define CLR_INV       1
`define CTRL_RST      1'h0
`define CLKCFG_RST    8'h00
`define CLRCFG_RST    4'h0
`define MCCFG_RST     11'h000
`define MASK_RST      41'h000_0000_0000
`endif

/* File: logic/ptm_pkg.sv */
/*
 types shared by the product-term macrocell array; assumes nothing
*/
`default_nettype none
package ptm_pkg;
	typedef enum logic [1:0] {
		FF_D  = 2'h0,
		FF_T  = 2'h1,
		FF_JK = 2'h2,
		FF_SR = 2'h3
	} ff_kind_t;
	typedef enum logic [1:0] {
		SRC_PIN    = 2'h0,
		SRC_GLOBAL = 2'h1,
		SRC_LOCAL  = 2'h2
	} clk_src_t;
	typedef enum logic [1:0] {
		CLR_NONE = 2'h0,
		CLR_A    = 2'h1,
		CLR_B    = 2'h2
	} clr_sel_t;
endpackage
`default_nettype wire
